// File: hw/edge_irq_pkg.sv
// Package for the edge interrupt and pulse catch block
package edge_irq_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned NUM_INPUTS    = 6;

  // Qualification times in ns
  localparam int unsigned FAST_QUAL_NS  = 10_000;
  localparam int unsigned SLOW_QUAL_NS  = 50_000;
  localparam int unsigned FAST_QUAL_CYC = (FAST_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SLOW_QUAL_CYC = (SLOW_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // AC extension response delay in us, lower bound used
  localparam int unsigned AC_DELAY_US   = 25_000;
  localparam int unsigned AC_DELAY_CYC  = AC_DELAY_US * (CLK_HZ / 1_000_000);

  localparam int unsigned QCNT_W        = 12;
  localparam int unsigned ACNT_W        = 20;

  // Which inputs use the slow filter
  localparam logic [5:0]  SLOW_MASK     = 6'h24;

  // Register map
  localparam logic [7:0]  ADDR_STATUS   = 8'h00;
  localparam logic [7:0]  ADDR_MASK     = 8'h04;
  localparam logic [7:0]  ADDR_DISABLE  = 8'h08;
  localparam logic [7:0]  ADDR_CAUGHT   = 8'h0c;
  localparam logic [7:0]  ADDR_LEVEL    = 8'h10;
  localparam logic [7:0]  ADDR_AC_IN    = 8'h14;

  // Status layout: bits 5:0 rise, 11:6 fall, 17:12 caught
  localparam int unsigned STAT_W        = 18;
  localparam int unsigned RISE_LSB      = 0;
  localparam int unsigned FALL_LSB      = 6;
  localparam int unsigned CATCH_LSB     = 12;

  localparam logic [STAT_W-1:0] MASK_RST    = '0;
  localparam logic [5:0]        DISABLE_RST = 6'h00;

  typedef struct packed {
    logic [5:0] rise;
    logic [5:0] fall;
  } edge_req_t;

  typedef struct packed {
    logic [1:0]  htrans;
    logic        hwrite;
    logic [7:0]  haddr;
  } ahb_addr_t;

endpackage : edge_irq_pkg

// File: hw/edge_interrupt_pulse_catch.sv
// Edge interrupt and pulse catch front end with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module edge_interrupt_pulse_catch
  import edge_irq_pkg::*;
#(
  parameter int unsigned AC_DELAY = AC_DELAY_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [5:0]  fast_input,
  input  wire logic [5:0]  ac_input,
  output logic [5:0]       ac_level,
  output logic [5:0]       rise_vector,
  output logic [5:0]       fall_vector,
  output logic [5:0]       caught_pulse,
  output logic             irq
);

  // Filtered fast levels and delayed AC levels
  wire logic [5:0]   level_q;
  wire logic [5:0]   level_d;
  wire logic [5:0]   ac_q;

  // Edge requests of this cycle
  edge_req_t         req;

  // Address phase kept for the data phase
  ahb_addr_t         ap_q;
  ahb_addr_t         ap_d;

  // Software visible state
  logic [5:0]        disable_q;
  logic [5:0]        disable_d;
  logic [STAT_W-1:0] mask_q;
  logic [STAT_W-1:0] mask_d;
  logic [STAT_W-1:0] status_q;
  logic [STAT_W-1:0] status_d;
  logic              irq_d;

  // Output pulses
  logic [5:0]        rise_q;
  logic [5:0]        rise_d;
  logic [5:0]        fall_q;
  logic [5:0]        fall_d;

  // Read data path
  logic [31:0]       rdata_d;

  // Decoded accesses
  logic              rd_acc;
  logic              rd_stat;
  logic              wr_ph;
  logic              wr_disable;
  logic              wr_mask;
  logic              wr_caught;
  logic [5:0]        catch_set;

  // Per input filters
  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
    localparam logic [QCNT_W-1:0] QLIM = SLOW_MASK[i] ? QCNT_W'(SLOW_QUAL_CYC - 1)
                                                      : QCNT_W'(FAST_QUAL_CYC - 1);

    logic              lvl_q;
    logic              lvl_d;
    logic [QCNT_W-1:0] qcnt_q;
    logic [QCNT_W-1:0] qcnt_d;
    logic              acl_q;
    logic              acl_d;
    logic [ACNT_W-1:0] acnt_q;
    logic [ACNT_W-1:0] acnt_d;

    always_comb begin
      lvl_d  = lvl_q;
      qcnt_d = '0;
      if (fast_input[i] != lvl_q) begin
        if (qcnt_q == QLIM) begin
          lvl_d = fast_input[i];
        end else begin
          qcnt_d = qcnt_q + QCNT_W'(1);
        end
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lvl_q  <= 1'b0;
        qcnt_q <= '0;
      end else begin
        lvl_q  <= lvl_d;
        qcnt_q <= qcnt_d;
      end
    end

    always_comb begin
      acl_d  = acl_q;
      acnt_d = '0;
      if (ac_input[i] != acl_q) begin
        if (acnt_q >= ACNT_W'(AC_DELAY - 1)) begin
          acl_d = ac_input[i];
        end else begin
          acnt_d = acnt_q + ACNT_W'(1);
        end
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        acl_q  <= 1'b0;
        acnt_q <= '0;
      end else begin
        acl_q  <= acl_d;
        acnt_q <= acnt_d;
      end
    end

    assign level_q[i] = lvl_q;
    assign level_d[i] = lvl_d;
    assign ac_q[i]    = acl_q;
  end

  always_comb begin
    req.rise = level_d & ~level_q & ~disable_q;
    req.fall = ~level_d & level_q & ~disable_q;
  end

  // Address phase capture
  always_comb begin
    ap_d = ap_q;
    if (hready) begin
      ap_d.htrans = (hsel && htrans[1]) ? htrans : 2'b00;
      ap_d.hwrite = hwrite;
      ap_d.haddr  = haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
    end else begin
      ap_q <= ap_d;
    end
  end

  // Access decode
  always_comb begin
    rd_acc     = hsel && htrans[1] && !hwrite && hready;
    rd_stat    = rd_acc && (haddr[7:0] == ADDR_STATUS);
    wr_ph      = ap_q.htrans[1] && ap_q.hwrite;
    wr_disable = wr_ph && (ap_q.haddr == ADDR_DISABLE);
    wr_mask    = wr_ph && (ap_q.haddr == ADDR_MASK);
    wr_caught  = wr_ph && (ap_q.haddr == ADDR_CAUGHT);
  end

  always_comb begin
    disable_d = disable_q;
    mask_d    = mask_q;
    if (wr_disable) begin
      disable_d = hwdata[5:0];
    end
    if (wr_mask) begin
      mask_d = hwdata[STAT_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disable_q <= DISABLE_RST;
      mask_q    <= MASK_RST;
    end else begin
      disable_q <= disable_d;
      mask_q    <= mask_d;
    end
  end

  // Status flags, set wins over clear
  always_comb begin
    catch_set = level_d & ~level_q;
    status_d  = status_q;
    if (rd_stat) begin
      status_d = '0;
    end
    if (wr_caught) begin
      status_d[CATCH_LSB +: 6] = status_d[CATCH_LSB +: 6] & ~hwdata[5:0];
    end
    status_d[RISE_LSB +: 6]  = status_d[RISE_LSB +: 6] | req.rise;
    status_d[FALL_LSB +: 6]  = status_d[FALL_LSB +: 6] | req.fall;
    status_d[CATCH_LSB +: 6] = status_d[CATCH_LSB +: 6] | catch_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // Interrupt level
  always_comb begin
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  always_comb begin
    rise_d = req.rise;
    fall_d = req.fall;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  // Read data mux
  always_comb begin
    rdata_d = '0;
    if (rd_acc) begin
      unique case (haddr[7:0])
        ADDR_STATUS: begin
          rdata_d[STAT_W-1:0] = status_q;
        end
        ADDR_MASK: begin
          rdata_d[STAT_W-1:0] = mask_q;
        end
        ADDR_DISABLE: begin
          rdata_d[5:0] = disable_q;
        end
        ADDR_CAUGHT: begin
          rdata_d[5:0] = status_q[CATCH_LSB +: 6];
        end
        ADDR_LEVEL: begin
          rdata_d[5:0] = level_q;
        end
        ADDR_AC_IN: begin
          rdata_d[5:0] = ac_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else begin
      hrdata <= rdata_d;
    end
  end

  // Zero wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Outputs straight from flops
  assign rise_vector  = rise_q;
  assign fall_vector  = fall_q;
  assign caught_pulse = status_q[CATCH_LSB +: 6];
  assign ac_level     = ac_q;

endmodule : edge_interrupt_pulse_catch
`default_nettype wire

// File: bench/edge_irq_asserts.sv
// Assertions for the edge interrupt and pulse catch block
`timescale 1ns/1ps
`default_nettype none
module edge_irq_asserts (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic [5:0] fast_input,
  input wire logic [5:0] rise_vector,
  input wire logic [5:0] fall_vector,
  input wire logic [5:0] caught_pulse,
  input wire logic       hreadyout,
  input wire logic       hresp
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic acc_q;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) acc_q <= 1'b0;
    else acc_q <= hsel && htrans[1];
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready");
  rise_fall_a: assert property ((rise_vector & fall_vector) == 6'h0)
    else $error("rise and fall together");
  rise_pulse_a: assert property ((rise_vector & $past(rise_vector)) == 6'h0)
    else $error("rise longer than one cycle");
  fall_pulse_a: assert property ((fall_vector & $past(fall_vector)) == 6'h0)
    else $error("fall longer than one cycle");
  rise_held_a: assert property ((rise_vector & ~$past(fast_input, 8)) == 6'h0)
    else $error("rise without held input");
  fall_held_a: assert property ((fall_vector & $past(fast_input, 8)) == 6'h0)
    else $error("fall without held input");
  rise_catch_a: assert property ((rise_vector & ~caught_pulse) == 6'h0)
    else $error("rise without catch");
  catch_sticky_a: assert property ((~caught_pulse & $past(caught_pulse)) != 6'h0 |->
    acc_q || $past(acc_q)) else $error("catch lost without access");
  cover property (|rise_vector);
  cover property (|fall_vector);
  cover property ($fell(|caught_pulse));
endmodule : edge_irq_asserts
bind edge_interrupt_pulse_catch edge_irq_asserts i_edge_irq_asserts (.hclk, .hresetn,
  .hsel, .htrans, .fast_input, .rise_vector, .fall_vector, .caught_pulse, .hreadyout, .hresp);
`default_nettype wire

// File: bench/field_switches.sv
// Field switch model driving the fast and extension inputs
`timescale 1ns/1ps
`default_nettype none
module field_switches (
  input  wire logic       hclk,
  input  wire logic [5:0] want,
  input  wire logic [5:0] ac_want,
  output logic      [5:0] fast_input = 6'h0,
  output logic      [5:0] ac_input = 6'h0
);
  always @(posedge hclk) begin
    fast_input <= want;
    ac_input   <= ac_want;
  end
endmodule : field_switches
`default_nettype wire

// File: bench/testbench.sv
// Testbench for the edge interrupt and pulse catch block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import edge_irq_pkg::*;
  typedef struct {logic [5:0] dis; logic [17:0] msk; logic [5:0] fin; int hold;
    logic [31:0] stat; logic irq;} row_t;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [5:0] want = '0, ac_want = '0, fast_input, ac_input, ac_level;
  logic [5:0] rise_vector, fall_vector, caught_pulse;
  int errors = 0, samples_checked = 0;
  row_t rows[9] = '{'{6'h00, 18'h0, 6'h3f, 2100, 32'h3f03f, 1'b0},
    '{6'h00, 18'h0, 6'h00, 2100, 32'hfc0, 1'b0}, '{6'h3f, 18'h0, 6'h3f, 2100, 32'h3f000, 1'b0},
    '{6'h00, 18'h0, 6'h00, 2100, 32'hfc0, 1'b0}, '{6'h00, 18'h0, 6'h04, 1900, 32'h0, 1'b0},
    '{6'h00, 18'h0, 6'h00, 2100, 32'h0, 1'b0}, '{6'h00, 18'h0, 6'h01, 390, 32'h0, 1'b0},
    '{6'h00, 18'h1, 6'h01, 2100, 32'h1001, 1'b1}, '{6'h00, 18'h3f000, 6'h00, 2100, 32'h40, 1'b0}};
  edge_interrupt_pulse_catch #(.AC_DELAY(8)) i_edge_interrupt_pulse_catch (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .fast_input, .ac_input, .ac_level, .rise_vector, .fall_vector,
    .caught_pulse, .irq);
  field_switches i_field_switches (.hclk, .want, .ac_want, .fast_input, .ac_input);
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (!hreadyout);
    rd = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial forever #12.5 hclk = ~hclk;
  initial begin
    repeat (40000) @(posedge hclk);
    errors++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, ADDR_DISABLE, 32'(rows[i].dis));
      bus(1'b1, ADDR_MASK, 32'(rows[i].msk));
      want <= rows[i].fin;
      repeat (rows[i].hold) @(posedge hclk);
      #1;
      chk(32'(irq), 32'(rows[i].irq));
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, rows[i].stat);
      @(posedge hclk);
      #1;
      chk(32'(irq), 32'h0);
    end
    want <= 6'h02;
    repeat (2100) @(posedge hclk);
    want <= 6'h00;
    repeat (2100) @(posedge hclk);
    #1;
    chk(32'(caught_pulse), 32'h2);
    bus(1'b1, ADDR_CAUGHT, 32'h2);
    bus(1'b0, ADDR_CAUGHT, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h82);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    ac_want <= 6'h15;
    repeat (3) @(posedge hclk);
    #1;
    chk(32'(ac_level), 32'h0);
    repeat (20) @(posedge hclk);
    #1;
    chk(32'(ac_level), 32'h15);
    want <= 6'h3f;
    repeat (2100) @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    chk(32'({hreadyout, irq, caught_pulse}), 32'h80);
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2100) @(posedge hclk);
    #1;
    chk(32'(caught_pulse), 32'h3f);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
